// ==== pkg/mca_global_pkg.sv ====
// constants, field layout and decode helpers for the global machine-check block
package mca_global_pkg;
  // clock and tick time bases
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned TB_MS_NS      = 1000000;
  localparam int unsigned TB_US_NS      = 1000;
  localparam int unsigned TB_5NS_NS     = 5;

  // a tick period never drops below one clock cycle
  function automatic int unsigned ns_to_cycles(input int unsigned ns);
    return (ns / CLK_PERIOD_NS) > 0 ? (ns / CLK_PERIOD_NS) : 1;
  endfunction

  localparam int unsigned TICK_MS_CYCLES = ns_to_cycles(TB_MS_NS);
  localparam int unsigned DIV_W          = 15;
  localparam int unsigned CNT_W          = 14;
  localparam logic [DIV_W-1:0] TICK_US_CYCLES  = DIV_W'(ns_to_cycles(TB_US_NS));
  localparam logic [DIV_W-1:0] TICK_5NS_CYCLES = DIV_W'(ns_to_cycles(TB_5NS_NS));

  // register indices on the msr port
  localparam int unsigned MSR_IDX_W = 32;
  localparam logic [MSR_IDX_W-1:0] MSR_GLOBAL_CAP    = 32'h0000_0c00;
  localparam logic [MSR_IDX_W-1:0] MSR_GLOBAL_STATUS = 32'h0000_0c01;
  localparam logic [MSR_IDX_W-1:0] MSR_GLOBAL_CTL    = 32'h0000_0c02;
  localparam logic [MSR_IDX_W-1:0] MSR_WDOG_CFG      = 32'h0000_0c03;

  // field positions
  localparam int unsigned CAP_BANKS_W   = 8;
  localparam int unsigned ST_RESTART    = 0;
  localparam int unsigned ST_FAULT_IP   = 1;
  localparam int unsigned ST_IN_PROG    = 2;
  localparam int unsigned ST_W          = 3;
  localparam int unsigned WD_EN         = 0;
  localparam int unsigned WD_TB_LSB     = 1;
  localparam int unsigned WD_CS_LSB     = 3;
  localparam int unsigned WD_W          = 7;
  localparam logic [ST_W-1:0] ST_RESET  = 3'h0;
  localparam logic [WD_W-1:0] WD_RESET  = 7'h00;
  localparam logic [63:0]     CTL_RESET = 64'h0;

  typedef enum logic [1:0] {
    TU_MS   = 2'h0,
    TU_US   = 2'h1,
    TU_5NS  = 2'h2,
    TU_RSVD = 2'h3
  } tick_unit_t;

  // count-select decode; zero marks a reserved code
  function automatic logic [CNT_W-1:0] count_limit(input logic [3:0] cs);
    case (cs)
      4'h0:    return 14'h0fff;
      4'h1:    return 14'h07ff;
      4'h2:    return 14'h03ff;
      4'h3:    return 14'h01ff;
      4'h4:    return 14'h00ff;
      4'h5:    return 14'h007f;
      4'h6:    return 14'h003f;
      4'h7:    return 14'h001f;
      4'h8:    return 14'h1fff;
      4'h9:    return 14'h3fff;
      default: return 14'h0000;
    endcase
  endfunction
endpackage

// ==== pkg/wdog_if.sv ====
// signals shared between the watchdog control, tick divider and counter
`timescale 1ns/1ps
interface wdog_if;
  import mca_global_pkg::*;
  logic             run;
  logic             restart;
  tick_unit_t       tick_unit;
  logic             tick;
  logic [CNT_W-1:0] limit;
  logic             expire;
  modport ctrl    (output run, restart, tick_unit, limit, input expire);
  modport tick_src(input run, restart, tick_unit, output tick);
  modport counter (input run, restart, tick, limit, output expire);
endinterface

// ==== design/wdog_tick_gen.sv ====
// time-base divider: one-cycle tick per selected watchdog unit
`timescale 1ns/1ps
module wdog_tick_gen #(
  parameter int unsigned MS_TICK_CYCLES = mca_global_pkg::TICK_MS_CYCLES
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  // watchdog bundle
  wdog_if.tick_src wd
);
  import mca_global_pkg::*;

  logic [DIV_W-1:0] div_q;
  logic [DIV_W-1:0] period;
  logic [DIV_W-1:0] gap_q;

  // period of one tick in clock cycles
  always_comb begin
    case (wd.tick_unit)
      TU_MS:   period = DIV_W'(MS_TICK_CYCLES);
      TU_US:   period = TICK_US_CYCLES;
      TU_5NS:  period = TICK_5NS_CYCLES;
      default: period = TICK_5NS_CYCLES;
    endcase
  end

  // divider holds while stopped so a halt does not lose a partial tick
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      div_q   <= '0;
      wd.tick <= 1'b0;
    end else if (wd.restart) begin
      div_q   <= '0;
      wd.tick <= 1'b0;
    end else if (wd.run) begin
      wd.tick <= (div_q == period - 15'h0001);
      div_q   <= (div_q == period - 15'h0001) ? '0 : div_q + 15'h0001;
    end else begin
      wd.tick <= 1'b0;
    end
  end

  // check helper: cycles in which the divider really advanced since the last tick
  // a unit change always comes with a restart, so one count covers every unit
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      gap_q <= '0;
    end else if (wd.restart) begin
      gap_q <= '0;
    end else if (wd.run) begin
      gap_q <= wd.tick ? 15'h0001 : gap_q + 15'h0001;
    end else if (wd.tick) begin
      gap_q <= '0;
    end
  end

  us_tick_gap_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    wd.tick && wd.tick_unit == TU_US |-> gap_q == TICK_US_CYCLES)
    else $error("microsecond tick spacing wrong");
endmodule

// ==== design/wdog_counter.sv ====
// watchdog tick counter: expires after limit ticks with no completion
`timescale 1ns/1ps
module wdog_counter (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  // watchdog bundle
  wdog_if.counter  wd
);
  import mca_global_pkg::*;

  logic [CNT_W-1:0] count_q;

  // a completion restarts the count; it beats a tick in the same cycle
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      count_q   <= '0;
      wd.expire <= 1'b0;
    end else if (wd.restart) begin
      count_q   <= '0;
      wd.expire <= 1'b0;
    end else if (wd.run && wd.tick) begin
      wd.expire <= (count_q == wd.limit - 14'h0001);
      count_q   <= (count_q == wd.limit - 14'h0001) ? '0 : count_q + 14'h0001;
    end else begin
      wd.expire <= 1'b0;
    end
  end

  expire_at_limit_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    wd.expire |-> $past(count_q) == $past(wd.limit) - 14'h0001)
    else $error("expiry not at programmed count");
  halt_holds_count_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    !wd.run && !wd.restart |=> $stable(count_q) && !wd.expire)
    else $error("counter moved while stopped");
  restart_clears_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    wd.restart |=> count_q == '0 && !wd.expire)
    else $error("completion did not restart count");
  wdog_expiry_c: cover property (@(posedge i_sys_clk) disable iff (!i_rstn) wd.expire);
endmodule

// ==== design/mca_global_watchdog.sv ====
// global machine-check status, control, capabilities and instruction watchdog
`timescale 1ns/1ps
module mca_global_watchdog #(
  parameter int unsigned BANK_COUNT     = 1,
  parameter bit          HAS_CTL        = 1'b1,
  parameter int unsigned WDOG_BANK      = 0,
  parameter int unsigned MS_TICK_CYCLES = mca_global_pkg::TICK_MS_CYCLES
) (
  // clock and resets
  input  wire logic                                i_sys_clk,
  input  wire logic                                i_rstn,
  input  wire logic                                i_warm_rst,
  // msr access port
  input  wire logic                                i_msr_rd,
  input  wire logic                                i_msr_wr,
  input  wire logic [mca_global_pkg::MSR_IDX_W-1:0] i_msr_index,
  input  wire logic [63:0]                         i_msr_wdata,
  output logic      [63:0]                         o_msr_rdata,
  output logic                                     o_msr_ack,
  output logic                                     o_msr_fault,
  // core indications
  input  wire logic                                i_insn_done,
  input  wire logic                                i_core_halted,
  input  wire logic                                i_stop_grant,
  input  wire logic                                i_err_valid,
  input  wire logic [7:0]                          i_err_bank,
  input  wire logic                                i_err_src_en,
  input  wire logic                                i_err_restartable,
  input  wire logic                                i_err_ip_caused,
  // exception and escalation
  output logic                                     o_mce,
  output logic                                     o_shutdown,
  output logic                                     o_check_in_progress
);
  import mca_global_pkg::*;

  localparam logic [CAP_BANKS_W-1:0] BANKS = CAP_BANKS_W'(BANK_COUNT);
  localparam logic [63:0] CTL_MASK =
    (BANK_COUNT >= 64) ? 64'hffff_ffff_ffff_ffff : ((64'h1 << BANK_COUNT) - 64'h1);
  // constant word; nothing in the block can alter it
  localparam logic [63:0] CAP_WORD = {55'h0, HAS_CTL, BANKS};

  logic [ST_W-1:0] status_q;
  logic [ST_W-1:0] status_d;
  logic [63:0]     ctl_q;
  logic [WD_W-1:0] wd_cfg_q;
  logic            shutdown_q;
  logic            sel_cap;
  logic            sel_status;
  logic            sel_ctl;
  logic            sel_wd;
  logic            hit;
  logic [63:0]     ctl_eff;
  logic            core_report;
  logic            wd_report;
  logic            mc_event;
  logic            deliver;
  tick_unit_t      tick_unit;
  logic [3:0]      cs_code;
  logic            wd_reserved;

  wdog_if wd ();

  // register decode; the control register vanishes when not built
  assign sel_cap    = (i_msr_index == MSR_GLOBAL_CAP);
  assign sel_status = (i_msr_index == MSR_GLOBAL_STATUS);
  assign sel_ctl    = (i_msr_index == MSR_GLOBAL_CTL) && HAS_CTL;
  assign sel_wd     = (i_msr_index == MSR_WDOG_CFG);
  assign hit        = sel_cap || sel_status || sel_ctl || sel_wd;

  // msr answer one cycle after the strobe; unmapped indices fault
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_msr_rdata <= '0;
      o_msr_ack   <= 1'b0;
      o_msr_fault <= 1'b0;
    end else begin
      o_msr_ack   <= i_msr_rd || i_msr_wr;
      o_msr_fault <= (i_msr_rd || i_msr_wr) && !hit;
      if (i_msr_rd) begin
        o_msr_rdata <= sel_cap    ? CAP_WORD :
                       sel_status ? {61'h0, status_q} :
                       sel_ctl    ? ctl_q :
                       sel_wd     ? {57'h0, wd_cfg_q} : 64'h0;
      end
    end
  end

  // global bank enables; only implemented banks hold a bit
  // cold reset only, so a warm reset keeps the enables
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ctl_q <= CTL_RESET;
    end else if (i_msr_wr && sel_ctl) begin
      ctl_q <= i_msr_wdata & CTL_MASK;
    end
  end

  // without a control register every bank counts as enabled
  assign ctl_eff = HAS_CTL ? ctl_q : CTL_MASK;

  // reporting gate per source
  assign core_report = i_err_valid && i_err_src_en && (32'(i_err_bank) < BANK_COUNT)
                       && ctl_eff[i_err_bank[5:0]];
  assign wd_report   = wd.expire && ctl_eff[WDOG_BANK];
  assign mc_event    = (core_report || wd_report) && !shutdown_q;
  assign deliver     = mc_event && !status_q[ST_IN_PROG];

  // status next value: hardware setting wins over a clearing write
  always_comb begin
    status_d = status_q;
    if (i_msr_wr && sel_status) begin
      status_d = i_msr_wdata[ST_W-1:0];
    end
    if (deliver) begin
      // a watchdog expiry leaves no restartable or faulting instruction
      status_d[ST_RESTART]  = core_report && i_err_restartable;
      status_d[ST_FAULT_IP] = core_report && i_err_ip_caused;
      status_d[ST_IN_PROG]  = 1'b1;
    end
  end

  // global status keeps its content across warm reset
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      status_q <= ST_RESET;
    end else begin
      status_q <= status_d;
    end
  end

  // exception pulse and shutdown escalation; warm reset clears shutdown
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_mce      <= 1'b0;
      shutdown_q <= 1'b0;
    end else if (i_warm_rst) begin
      o_mce      <= 1'b0;
      shutdown_q <= 1'b0;
    end else begin
      o_mce <= deliver;
      if (mc_event && status_q[ST_IN_PROG]) begin
        shutdown_q <= 1'b1;
      end
    end
  end

  assign o_shutdown = shutdown_q;

  // in-progress mirrored from its own flop for the core
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_check_in_progress <= 1'b0;
    end else begin
      o_check_in_progress <= status_d[ST_IN_PROG];
    end
  end

  // watchdog configuration; cleared by warm reset as it is not error state
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wd_cfg_q <= WD_RESET;
    end else if (i_warm_rst) begin
      wd_cfg_q <= WD_RESET;
    end else if (i_msr_wr && sel_wd) begin
      wd_cfg_q <= i_msr_wdata[WD_W-1:0];
    end
  end

  // watchdog control: reserved codes park the timer
  assign tick_unit   = tick_unit_t'(wd_cfg_q[WD_TB_LSB +: 2]);
  assign cs_code     = wd_cfg_q[WD_CS_LSB +: 4];
  assign wd_reserved = (tick_unit == TU_RSVD) || (count_limit(cs_code) == '0);
  assign wd.tick_unit = tick_unit;
  assign wd.limit     = count_limit(cs_code);
  assign wd.run       = wd_cfg_q[WD_EN] && !wd_reserved && !shutdown_q
                        && !i_core_halted && !i_stop_grant;
  assign wd.restart   = i_insn_done || !wd_cfg_q[WD_EN] || wd_reserved
                        || (i_msr_wr && sel_wd);

  wdog_tick_gen #(
    .MS_TICK_CYCLES(MS_TICK_CYCLES)
  ) u_tick (
    .i_sys_clk(i_sys_clk),
    .i_rstn   (i_rstn),
    .wd       (wd)
  );

  wdog_counter u_count (
    .i_sys_clk(i_sys_clk),
    .i_rstn   (i_rstn),
    .wd       (wd)
  );

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);

  cap_bank_count_a: assert property (i_msr_rd && sel_cap |=> o_msr_rdata[7:0] == BANKS)
    else $error("bank count field wrong");
  cap_ctl_present_a: assert property (i_msr_rd && sel_cap |=> o_msr_rdata[8] == HAS_CTL)
    else $error("control-present bit wrong");
  cap_reserved_zero_a: assert property (i_msr_rd && sel_cap |=> o_msr_rdata[63:9] == '0)
    else $error("reserved capability bits not zero");
  restart_flag_a: assert property (deliver && core_report && !i_warm_rst |=>
    status_q[ST_RESTART] == $past(i_err_restartable) && o_mce)
    else $error("restart-valid flag wrong after check");
  fault_ip_flag_a: assert property (deliver |=>
    status_q[ST_FAULT_IP] == $past(core_report && i_err_ip_caused))
    else $error("faulting-pointer flag wrong after check");
  inprog_set_a: assert property (o_mce |-> status_q[ST_IN_PROG] && o_check_in_progress)
    else $error("exception without in-progress flag");
  shutdown_escalate_a: assert property (mc_event && status_q[ST_IN_PROG] && !i_warm_rst
    |=> o_shutdown && !o_mce)
    else $error("nested check did not shut down");
  inprog_sticky_a: assert property (status_q[ST_IN_PROG] && !(i_msr_wr && sel_status)
    |=> status_q[ST_IN_PROG])
    else $error("in-progress cleared by hardware");
  ctl_write_a: assert property (i_msr_wr && sel_ctl |=> ctl_q == ($past(i_msr_wdata) & CTL_MASK))
    else $error("bank enable write lost");
  warm_keeps_a: assert property (i_warm_rst && !i_msr_wr && !deliver
    |=> $stable(ctl_q) && $stable(status_q))
    else $error("warm reset disturbed error registers");
  report_gate_a: assert property (o_mce |-> $past(core_report || wd_report))
    else $error("check delivered from disabled source");
  reserved_stops_a: assert property (wd_reserved |=> ##1 !wd.expire)
    else $error("reserved setting let watchdog expire");

  // register port: capability writes are taken and dropped, registers read back
  cap_write_quiet_a: assert property (i_msr_wr && sel_cap
    |=> o_msr_ack && !o_msr_fault)
    else $error("capability write refused or faulted");
  unmapped_fault_a: assert property (i_msr_rd && !hit
    |=> o_msr_fault && o_msr_rdata == 64'h0)
    else $error("unmapped read not faulted");
  ctl_all_ones_a: assert property (i_msr_wr && sel_ctl && i_msr_wdata == '1
    |=> ctl_q == CTL_MASK)
    else $error("all-ones write left a bank disabled");
  ctl_read_back_a: assert property (i_msr_rd && sel_ctl
    |=> o_msr_rdata == $past(ctl_q))
    else $error("bank enables read back wrong");
  status_read_back_a: assert property (i_msr_rd && sel_status
    |=> o_msr_rdata == {61'h0, $past(status_q)})
    else $error("status read back wrong");
  status_write_a: assert property (i_msr_wr && sel_status && !deliver
    |=> status_q == $past(i_msr_wdata[ST_W-1:0]))
    else $error("status write not taken");

  // exception delivery and escalation; a second check never sneaks through
  inprog_mirror_a: assert property (1'b1 |-> o_check_in_progress == status_q[ST_IN_PROG])
    else $error("in-progress output disagrees with status");
  mce_one_cycle_a: assert property (o_mce |=> !o_mce)
    else $error("exception pulse longer than one cycle");
  inprog_blocks_mce_a: assert property (status_q[ST_IN_PROG] |=> !o_mce)
    else $error("exception delivered while in progress");
  wdog_fields_zero_a: assert property (deliver && !core_report
    |=> !status_q[ST_RESTART] && !status_q[ST_FAULT_IP])
    else $error("watchdog check left pointer flags set");
  shutdown_sticky_a: assert property (o_shutdown && !i_warm_rst |=> o_shutdown)
    else $error("shutdown dropped without a reset");
  shutdown_quiet_a: assert property (o_shutdown |=> !o_mce)
    else $error("exception delivered in shutdown");
  source_gate_a: assert property (i_err_valid && !i_err_src_en
    && !wd_report |=> !o_mce)
    else $error("exception from a disabled source");
  bank_gate_a: assert property (i_err_valid && !ctl_eff[i_err_bank[5:0]]
    && !wd_report |=> !o_mce)
    else $error("exception from a disabled bank");

  // watchdog gating seen from the top
  wdog_off_quiet_a: assert property (!wd_cfg_q[WD_EN] |=> ##1 !wd.expire)
    else $error("disabled watchdog expired");
  halt_no_expiry_a: assert property (i_core_halted || i_stop_grant |=> !wd.expire)
    else $error("watchdog expired during halt");
  wdog_reports_a: assert property (wd.expire && ctl_eff[WDOG_BANK] && !shutdown_q
    && !status_q[ST_IN_PROG] && !i_warm_rst |=> o_mce)
    else $error("watchdog expiry not delivered");

  check_delivered_c: cover property (o_mce);
  shutdown_entered_c: cover property (!o_shutdown ##1 o_shutdown);
  wdog_check_c: cover property (wd_report && deliver);
  wdog_restart_c: cover property (i_insn_done && wd.run);
endmodule

// ==== tb/core_model.sv ====
// behavioural core pipeline: completions, halt states and error events
`timescale 1ns/1ps
module core_model (
  // clock
  input  wire logic       i_sys_clk,
  // core indications
  output logic            o_insn_done,
  output logic            o_core_halted,
  output logic            o_stop_grant,
  output logic            o_err_valid,
  output logic [7:0]      o_err_bank,
  output logic            o_err_src_en,
  output logic            o_err_restartable,
  output logic            o_err_ip_caused
);
  // quiet core at time zero
  initial begin
    {o_insn_done, o_core_halted, o_stop_grant, o_err_valid} = 4'h0;
    {o_err_bank, o_err_src_en, o_err_restartable, o_err_ip_caused} = 11'h0;
  end
  // one-cycle error pulse; detail lines turn to junk once the pulse is gone
  task automatic raise_err(input logic [7:0] b, input logic en, r, p);
    @(negedge i_sys_clk);
    {o_err_valid, o_err_bank, o_err_src_en, o_err_restartable, o_err_ip_caused} = {1'b1, b, en, r, p};
    @(negedge i_sys_clk);
    {o_err_valid, o_err_bank, o_err_src_en, o_err_restartable, o_err_ip_caused} = {1'b0, ~b, ~en, ~r, ~p};
  endtask
  // one retired instruction
  task automatic complete_insn();
    @(negedge i_sys_clk);
    o_insn_done = 1'b1;
    @(negedge i_sys_clk);
    o_insn_done = 1'b0;
  endtask
  // halt and stop-grant levels
  task automatic set_hold(input logic h, s);
    @(negedge i_sys_clk);
    o_core_halted = h;
    o_stop_grant  = s;
  endtask
endmodule

// ==== tb/machine_check_global_and_watchdog_bench.sv ====
// self-checking bench for the global machine-check block and its watchdog
`timescale 1ns/1ps
module machine_check_global_and_watchdog_bench;
  import mca_global_pkg::*;
  localparam int unsigned MS_T = 40;  // shortened millisecond tick keeps the run short
  logic        i_sys_clk, i_rstn, warm, rd, wr, ack, fault, mce, sd, cip;
  logic        done, halt, stopg, ev, src_en, rs, ip;
  logic [7:0]  bank;
  logic [31:0] idx;
  logic [63:0] wdata, rdata;
  logic [2:0]  m_st;  // model of the status register
  logic        m_ctl, m_sd;
  int          n_errors, check_count, cycles, seed;
  int          lim [10] = '{4095, 2047, 1023, 511, 255, 127, 63, 31, 8191, 16383};

  core_model core (.i_sys_clk(i_sys_clk), .o_insn_done(done), .o_core_halted(halt),
    .o_stop_grant(stopg), .o_err_valid(ev), .o_err_bank(bank), .o_err_src_en(src_en),
    .o_err_restartable(rs), .o_err_ip_caused(ip));
  mca_global_watchdog #(.BANK_COUNT(1), .HAS_CTL(1'b1), .MS_TICK_CYCLES(MS_T)) DUT (
    .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_warm_rst(warm), .i_msr_rd(rd), .i_msr_wr(wr),
    .i_msr_index(idx), .i_msr_wdata(wdata), .o_msr_rdata(rdata), .o_msr_ack(ack),
    .o_msr_fault(fault), .i_insn_done(done), .i_core_halted(halt), .i_stop_grant(stopg),
    .i_err_valid(ev), .i_err_bank(bank), .i_err_src_en(src_en), .i_err_restartable(rs),
    .i_err_ip_caused(ip), .o_mce(mce), .o_shutdown(sd), .o_check_in_progress(cip));

  // 20 MHz clock
  initial begin
    i_sys_clk = 1'b0;
    forever #25 i_sys_clk = ~i_sys_clk;
  end
  // hang guard, well above the longest expected run
  always @(posedge i_sys_clk) begin
    cycles++;
    if (cycles == 60000) begin
      n_errors++;
      close_out();
    end
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic check(input logic [63:0] seen, exp, input string what);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  function automatic logic [63:0] wcfg(input int cs, tb, en);
    return {57'h0, 4'(cs), 2'(tb), 1'(en)};
  endfunction
  // one msr access; the answer is registered on the taking edge and checked half a cycle later
  task automatic msr(input logic w, input logic [31:0] i, input logic [63:0] d);
    @(negedge i_sys_clk);
    wr = w;
    rd = !w;
    idx = i;
    wdata = d;
    @(negedge i_sys_clk);
    wr = 1'b0;
    rd = 1'b0;
    idx = ~i;
    wdata = ~d;
    check(64'(ack), 64'h1, "ack");
    check(64'(fault), 64'(i < MSR_GLOBAL_CAP || i > MSR_WDOG_CFG), "fault");
  endtask
  task automatic rd_chk(input logic [31:0] i, input logic [63:0] exp);
    msr(1'b0, i, 64'h0);
    check(rdata, exp, "read data");
  endtask
  // handler done: software drops the in-progress flag
  task automatic clear_status();
    msr(1'b1, MSR_GLOBAL_STATUS, 64'h0);
    m_st = 3'h0;
  endtask
  // error event with random detail bits, predicted by the model
  task automatic err(input logic [7:0] b, input logic en);
    logic r, p, take;
    r = 1'($random(seed));
    p = 1'($random(seed));
    take = en && b == 8'h00 && m_ctl && !m_sd;
    core.raise_err(b, en, r, p);
    check(64'(mce), 64'(take && !m_st[2]), "exception");
    if (take && m_st[2]) m_sd = 1'b1;
    else if (take) m_st = {1'b1, p, r};
    check(64'(sd), 64'(m_sd), "shutdown");
    check(64'(cip), 64'(m_st[2]), "in progress");
    rd_chk(MSR_GLOBAL_STATUS, 64'(m_st));
  endtask
  // wait for a watchdog exception; lo equal to hi means none may come
  task automatic wait_mce(input int lo, hi);
    int n;
    n = 0;
    while (mce !== 1'b1 && n < hi) begin
      @(negedge i_sys_clk);
      n++;
    end
    check(64'(n >= lo && (n < hi || lo == hi)), 64'h1, "expiry timing");
    if (mce === 1'b1) begin
      m_st = 3'h4;
      rd_chk(MSR_GLOBAL_STATUS, 64'h4);
      clear_status();
    end
  endtask

  initial begin
    seed = 90;
    {i_rstn, warm, rd, wr} = 4'h0;
    idx = 32'h0;
    wdata = 64'h0;
    {m_st, m_ctl, m_sd} = 5'h0;
    repeat (8) @(negedge i_sys_clk);
    i_rstn = 1'b1;
    // capabilities are read-only; an unmapped index faults
    rd_chk(MSR_GLOBAL_CAP, 64'h101);
    msr(1'b1, MSR_GLOBAL_CAP, 64'hffff_ffff_ffff_ffff);
    rd_chk(MSR_GLOBAL_CAP, 64'h101);
    rd_chk(32'h0000_0c04, 64'h0);
    // reporting needs both the bank enable and the source enable
    err(8'h00, 1'b1);
    msr(1'b1, MSR_GLOBAL_CTL, 64'hffff_ffff_ffff_ffff);
    m_ctl = 1'b1;
    rd_chk(MSR_GLOBAL_CTL, 64'h1);
    err(8'h00, 1'b0);
    err(8'h01, 1'b1);
    repeat (4) begin
      err(8'h00, 1'b1);
      clear_status();
    end
    // an unhandled check escalates, and the flag never drops by itself
    err(8'h00, 1'b1);
    repeat (50) @(negedge i_sys_clk);
    check(64'(cip), 64'h1, "flag kept");
    err(8'h00, 1'b1);
    err(8'h00, 1'b1);
    // warm reset ends shutdown but keeps logged state
    msr(1'b1, MSR_WDOG_CFG, wcfg(7, 2, 1));
    @(negedge i_sys_clk);
    warm = 1'b1;
    @(negedge i_sys_clk);
    warm = 1'b0;
    m_sd = 1'b0;
    check(64'(sd), 64'h0, "warm shutdown");
    rd_chk(MSR_GLOBAL_STATUS, 64'(m_st));
    rd_chk(MSR_GLOBAL_CTL, 64'h1);
    rd_chk(MSR_WDOG_CFG, 64'h0);
    m_st = 3'($random(seed));
    msr(1'b1, MSR_GLOBAL_STATUS, 64'(m_st));
    rd_chk(MSR_GLOBAL_STATUS, 64'(m_st));
    clear_status();
    // count codes 0 to 9 on the 5 ns base, one clock per tick here
    for (int c = 0; c < 10; c++) begin
      msr(1'b1, MSR_WDOG_CFG, wcfg(c, 2, 1));
      wait_mce(lim[c] - 2, lim[c] + 5);
    end
    msr(1'b1, MSR_WDOG_CFG, wcfg(7, 1, 1));
    wait_mce(31 * 20 - 2, 31 * 20 + 25);
    msr(1'b1, MSR_WDOG_CFG, wcfg(7, 0, 1));
    wait_mce(31 * MS_T - 2, 31 * MS_T + 45);
    // completions keep restarting the count
    msr(1'b1, MSR_WDOG_CFG, wcfg(7, 2, 1));
    repeat (5) begin
      wait_mce(20, 20);
      core.complete_insn();
    end
    wait_mce(29, 36);
    // halt and stop-grant freeze the count without clearing it
    msr(1'b1, MSR_WDOG_CFG, wcfg(7, 2, 1));
    repeat (10) @(negedge i_sys_clk);
    core.set_hold(1'b1, 1'b0);
    wait_mce(100, 100);
    core.set_hold(1'b0, 1'b1);
    wait_mce(100, 100);
    core.set_hold(1'b0, 1'b0);
    wait_mce(14, 26);
    // disabled timer and reserved codes never expire
    for (int c = 0; c < 8; c++) begin
      msr(1'b1, MSR_WDOG_CFG, c == 0 ? wcfg(7, 2, 0) : c == 1 ? wcfg(7, 3, 1) : wcfg(c + 8, 2, 1));
      wait_mce(100, 100);
    end
    close_out();
  end
endmodule
